/* hw/itt_map.svh */
// Constants of the interval tick timer: offsets, fields, resets, counts.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef ITT_MAP_SVH
`define ITT_MAP_SVH

// Control register address on the special-function register bus
`define ITT_CTRL_ADDR 8'h9c
`define ITT_CTRL_RESET 8'h00

// Field positions in the control register
`define ITT_FLAG_BIT 7
`define ITT_RUN_BIT 6
`define ITT_CLEAR_BIT 5
`define ITT_SEL_MSB 2
`define ITT_SEL_LSB 0

// Oscillator and base tick
`define ITT_OSC_MHZ 24
`define ITT_TICK_OSC_CYCLES 128
`define ITT_ACC_W 7
`define ITT_DIV_W 3

// Base tick spans of the 100 us pulse, longest first
`define ITT_SPAN_LONG 5'h13
`define ITT_SPAN_SHORT 5'h12
`define ITT_SHORT_PHASE 2'h3

// Lowest select value that runs the upper stage
`define ITT_UPPER_MIN_SEL 3'h3

// Pulses of 100 us per interval for the upper stage
`define ITT_PULSES_400US 6'h04
`define ITT_PULSES_800US 6'h08
`define ITT_PULSES_1MS 6'h0a
`define ITT_PULSES_2MS 6'h14
`define ITT_PULSES_5MS 6'h32

`endif

/* hw/itt_pkg.sv */
// Types shared by the interval tick timer modules.
// Assumes itt_map.svh is on the include path.
`include "itt_map.svh"

package itt_pkg;

  // Interval select codes, in order from disabled to 5 ms
  typedef enum logic [2:0] {
    ITT_OFF,
    ITT_100US,
    ITT_200US,
    ITT_400US,
    ITT_800US,
    ITT_1MS,
    ITT_2MS,
    ITT_5MS
  } itt_interval_t;

  // Software-visible control state
  typedef struct packed {
    logic flag;
    logic run;
    itt_interval_t sel;
  } itt_ctrl_t;

  // Special-function register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } itt_sfr_req_t;

endpackage : itt_pkg

/* hw/itt_interval_counter.sv */
// Interval counter: 100 us pulse stage and the upper interval stage.
// Assumes one-cycle base tick pulses, synchronous to the system clock.
`timescale 1ns/10ps
`include "itt_map.svh"

module itt_interval_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic clear,
  input wire logic tick,
  input wire itt_pkg::itt_interval_t sel,
  output logic pulse_100us,
  output logic interval_event
);

  logic [4:0] tick_cnt_reg;
  logic [1:0] phase_reg;
  logic [5:0] pulse_cnt_reg;
  logic [4:0] span_last;
  logic pulse_now;
  logic upper_run;
  logic upper_done;
  logic event_now;

  // Pulses of 100 us that make up one long interval
  function automatic logic [5:0] pulses_for(
    input itt_pkg::itt_interval_t s
  );
    case (s)
      itt_pkg::ITT_400US: pulses_for = `ITT_PULSES_400US;
      itt_pkg::ITT_800US: pulses_for = `ITT_PULSES_800US;
      itt_pkg::ITT_1MS: pulses_for = `ITT_PULSES_1MS;
      itt_pkg::ITT_2MS: pulses_for = `ITT_PULSES_2MS;
      itt_pkg::ITT_5MS: pulses_for = `ITT_PULSES_5MS;
      default: pulses_for = `ITT_PULSES_400US;
    endcase
  endfunction : pulses_for

  // Fourth span is one tick shorter, giving 18.75 ticks on average
  assign span_last = (phase_reg == `ITT_SHORT_PHASE) ?
                     (`ITT_SPAN_SHORT - 5'h01) : (`ITT_SPAN_LONG - 5'h01);
  assign pulse_now = run && tick && (tick_cnt_reg == span_last);
  assign upper_run = run && (sel >= `ITT_UPPER_MIN_SEL);
  assign upper_done = (pulse_cnt_reg == (pulses_for(sel) - 6'h01));

  always_comb begin
    case (sel)
      itt_pkg::ITT_OFF: event_now = 1'b0;
      itt_pkg::ITT_100US: event_now = pulse_now;
      itt_pkg::ITT_200US: event_now = pulse_now && phase_reg[0];
      default: event_now = pulse_now && upper_run && upper_done;
    endcase
  end

  // Lower stage: ticks within a span, and the span phase
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      tick_cnt_reg <= 5'h00;
      phase_reg <= 2'h0;
    end else if (run && tick) begin
      if (pulse_now) begin
        tick_cnt_reg <= 5'h00;
        phase_reg <= phase_reg + 2'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 5'h01;
      end
    end
  end

  // Upper stage: counts 100 us pulses for 400 us and longer
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      pulse_cnt_reg <= 6'h00;
    end else if (pulse_now && upper_run) begin
      if (upper_done) begin
        pulse_cnt_reg <= 6'h00;
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_100us <= 1'b0;
      interval_event <= 1'b0;
    end else begin
      pulse_100us <= pulse_now && !clear;
      interval_event <= event_now && !clear;
    end
  end

endmodule : itt_interval_counter

/* hw/itt_timer.sv */
// Interval tick timer: base tick prescaler, control register, flag.
// Assumes a synchronous register bus from the processor core, a one-cycle
// prescaler clear strobe from the clock generator register, and the
// system clock divide exponent as a level on SYS_DIV.
`timescale 1ns/10ps
`include "itt_map.svh"

module itt_timer #(
  parameter int ACC_W = `ITT_ACC_W,
  parameter int DIV_W = `ITT_DIV_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  input wire logic [DIV_W-1:0] SYS_DIV,
  input wire logic TICK_PRESCALER_CLEAR,
  output logic [7:0] SFR_RDATA,
  output logic BASE_TICK,
  output logic PULSE_100US,
  output logic IRQ
);

  itt_pkg::itt_sfr_req_t req;
  itt_pkg::itt_ctrl_t ctrl_reg;
  itt_pkg::itt_ctrl_t ctrl_next;

  logic ctrl_hit;
  logic ctrl_write;
  logic ctrl_read;
  logic counter_clear;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W:0] acc_sum;
  logic tick_carry;
  logic base_tick_reg;

  logic pulse_100us;
  logic interval_event;

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;

  // Reset image of the control register, taken apart field by field
  localparam logic [7:0] ctrl_rst_val = `ITT_CTRL_RESET;

  // Oscillator cycles that one system clock cycle stands for
  function automatic logic [ACC_W:0] osc_per_cycle(
    input logic [DIV_W-1:0] div
  );
    logic [ACC_W:0] one;
    one = {{ACC_W{1'b0}}, 1'b1};
    osc_per_cycle = one << div;
  endfunction : osc_per_cycle

  // Control register image as software reads it
  function automatic logic [7:0] ctrl_image(
    input itt_pkg::itt_ctrl_t c
  );
    logic [7:0] v;
    v = 8'h00;
    v[`ITT_FLAG_BIT] = c.flag;
    v[`ITT_RUN_BIT] = c.run;
    v[`ITT_CLEAR_BIT] = 1'b0;
    v[`ITT_SEL_MSB:`ITT_SEL_LSB] = c.sel;
    ctrl_image = v;
  endfunction : ctrl_image

  // Bus request gathered into one carrier
  always_comb begin
    req.addr = SFR_ADDR;
    req.wdata = SFR_WDATA;
    req.we = SFR_WE;
    req.re = SFR_RE;
  end

  assign ctrl_hit = (req.addr == `ITT_CTRL_ADDR);
  assign ctrl_write = req.we && ctrl_hit;
  assign ctrl_read = req.re && ctrl_hit;

  // Clear strobe acts on the write cycle and is never stored
  assign counter_clear = ctrl_write && req.wdata[`ITT_CLEAR_BIT];

  // ------------------------------------------------------------------
  // Base tick prescaler
  // ------------------------------------------------------------------

  // Each system clock adds 2^div oscillator cycles; a carry out of the
  // 7-bit accumulator marks 128 oscillator cycles
  assign acc_sum = {1'b0, acc_reg} + osc_per_cycle(SYS_DIV);
  assign tick_carry = acc_sum[ACC_W];

  always_comb begin
    acc_next = acc_reg;
    if (TICK_PRESCALER_CLEAR) begin
      acc_next = {ACC_W{1'b0}};
    end else if (ctrl_reg.run) begin
      acc_next = acc_sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      acc_reg <= {ACC_W{1'b0}};
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Tick is high for one cycle per 128 oscillator cycles, suppressed while halted or cleared
  always_ff @(posedge CLK) begin
    if (RESET) begin
      base_tick_reg <= 1'b0;
    end else begin
      base_tick_reg <= ctrl_reg.run && tick_carry &&
                       !TICK_PRESCALER_CLEAR;
    end
  end

  // ------------------------------------------------------------------
  // Interval counter
  // ------------------------------------------------------------------

  itt_interval_counter u_counter (
    .clk(CLK),
    .reset(RESET),
    .run(ctrl_reg.run),
    .clear(counter_clear),
    .tick(base_tick_reg),
    .sel(ctrl_reg.sel),
    .pulse_100us(pulse_100us),
    .interval_event(interval_event)
  );

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------

  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_write) begin
      ctrl_next.flag = req.wdata[`ITT_FLAG_BIT];
      ctrl_next.run = req.wdata[`ITT_RUN_BIT];
      ctrl_next.sel = itt_pkg::itt_interval_t'(
        req.wdata[`ITT_SEL_MSB:`ITT_SEL_LSB]);
    end
    // An elapsed interval beats a clearing write in the same cycle
    if (interval_event) begin
      ctrl_next.flag = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg.flag <= ctrl_rst_val[`ITT_FLAG_BIT];
      ctrl_reg.run <= ctrl_rst_val[`ITT_RUN_BIT];
      ctrl_reg.sel <= itt_pkg::itt_interval_t'(
        ctrl_rst_val[`ITT_SEL_MSB:`ITT_SEL_LSB]);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ------------------------------------------------------------------
  // Read data and outputs
  // ------------------------------------------------------------------

  // Read answer stands for one cycle; other addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (ctrl_read) begin
      rdata_next = ctrl_image(ctrl_reg);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Request line mirrors the flag with no extra delay
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ctrl_next.flag;
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign BASE_TICK = base_tick_reg;
  assign PULSE_100US = pulse_100us;
  assign IRQ = irq_reg;

endmodule : itt_timer

/* tb/itt_timer_chk.sv */
// Port checker of the interval tick timer.
// Assumes binding to itt_timer; sees its ports only.
`timescale 1ns/10ps
module itt_timer_chk #(
  parameter int ACC_W = 7,
  parameter int DIV_W = 3
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  input wire logic [DIV_W-1:0] SYS_DIV,
  input wire logic TICK_PRESCALER_CLEAR,
  input wire logic [7:0] SFR_RDATA,
  input wire logic BASE_TICK,
  input wire logic PULSE_100US,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  logic [4:0] span_reg;
  logic seen_reg;
  logic hit;
  assign hit = SFR_ADDR == 8'h9c;
  // Base ticks since the last pulse; a counter clear restarts the span
  always_ff @(posedge CLK) begin
    if (RESET || (SFR_WE && hit && SFR_WDATA[5])) begin
      span_reg <= 5'h00;
      seen_reg <= 1'b0;
    end else if (PULSE_100US) begin
      span_reg <= {4'h0, BASE_TICK};
      seen_reg <= 1'b1;
    end else begin
      span_reg <= span_reg + {4'h0, BASE_TICK};
    end
  end
  span_len_a: assert property (
    PULSE_100US && seen_reg |-> span_reg inside {5'h12, 5'h13})
    else $error("pulse span wrong");
  tick_slow_a: assert property (
    BASE_TICK && SYS_DIV == 3'h0
    |=> (!BASE_TICK || SYS_DIV != 3'h0) [*8])
    else $error("base tick too soon");
  tick_div_a: assert property (
    BASE_TICK && SYS_DIV == 3'h3
    |=> (!BASE_TICK || SYS_DIV != 3'h3) [*8])
    else $error("divided tick too soon");
  tick_clear_a: assert property (
    TICK_PRESCALER_CLEAR && SYS_DIV == 3'h0 |-> ##2 !BASE_TICK [*8])
    else $error("tick after prescaler clear");
  flag_set_a: assert property (
    SFR_WE && hit && SFR_WDATA[7] |=> IRQ)
    else $error("flag not set by write");
  flag_hold_a: assert property (
    $fell(IRQ) |-> $past(SFR_WE && hit))
    else $error("flag cleared without write");
  read_flag_a: assert property (
    SFR_RE && hit |=> SFR_RDATA[7] == $past(IRQ))
    else $error("read flag differs from request");
  read_idle_a: assert property (
    !(SFR_RE && hit) |=> SFR_RDATA == 8'h00)
    else $error("read data not zero");
  read_resv_a: assert property (
    SFR_RDATA[5:3] == 3'h0)
    else $error("reserved bits not zero");
  pulse_one_a: assert property (
    PULSE_100US |=> !PULSE_100US)
    else $error("pulse longer than one cycle");
  cover property (PULSE_100US && seen_reg);
  cover property ($rose(IRQ));
  cover property (TICK_PRESCALER_CLEAR && SYS_DIV == 3'h0);
endmodule : itt_timer_chk

bind itt_timer itt_timer_chk #(.ACC_W(ACC_W), .DIV_W(DIV_W)) u_chk (
  .CLK, .RESET, .SFR_ADDR, .SFR_WDATA, .SFR_WE, .SFR_RE, .SYS_DIV,
  .TICK_PRESCALER_CLEAR, .SFR_RDATA, .BASE_TICK, .PULSE_100US, .IRQ);

/* tb/itt_core_model.sv */
// Processor core model: register bus cycles and the prescaler clear.
// Assumes a free-running CLK; tasks are called by the testbench.
`timescale 1ns/10ps
module itt_core_model (
  input wire logic CLK,
  input wire logic [7:0] SFR_RDATA,
  output logic [7:0] SFR_ADDR,
  output logic [7:0] SFR_WDATA,
  output logic SFR_WE,
  output logic SFR_RE,
  output logic TICK_PRESCALER_CLEAR
);
  initial begin
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    SFR_WE = 1'b0;
    SFR_RE = 1'b0;
    TICK_PRESCALER_CLEAR = 1'b0;
  end
  task automatic cyc(input logic [7:0] a, input logic [7:0] d,
                     input bit w);
    @(posedge CLK);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WE <= w;
    SFR_RE <= !w;
    @(posedge CLK);
    SFR_WE <= 1'b0;
    SFR_RE <= 1'b0;
    // Released lines carry no stale value
    SFR_ADDR <= ~a;
    SFR_WDATA <= ~d;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(a, 8'h00, 1'b0);
    #1 d = SFR_RDATA;
  endtask : rd
  task automatic tclr;
    @(posedge CLK);
    TICK_PRESCALER_CLEAR <= 1'b1;
    @(posedge CLK);
    TICK_PRESCALER_CLEAR <= 1'b0;
  endtask : tclr
  task automatic sync(input logic [7:0] ctrl);
    tclr();
    wr(8'h9c, ctrl | 8'h20);
    tclr();
  endtask : sync
endmodule : itt_core_model

/* tb/tb_top.sv */
// Testbench of the interval tick timer with a processor core model.
// Assumes the checker binds itself to itt_timer.
`timescale 1ns/10ps
module tb_top;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [2:0] SYS_DIV = 3'h7;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic SFR_WE, SFR_RE, TICK_PRESCALER_CLEAR, BASE_TICK, PULSE_100US, IRQ;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int exp_t [8] = '{400, 75, 150, 300, 600, 750, 1500, 3750};
  always #20 CLK = ~CLK;
  itt_core_model u_core (.CLK, .SFR_RDATA, .SFR_ADDR, .SFR_WDATA,
    .SFR_WE, .SFR_RE, .TICK_PRESCALER_CLEAR);
  itt_timer u_dut (.CLK, .RESET, .SFR_ADDR, .SFR_WDATA, .SFR_WE,
    .SFR_RE, .SYS_DIV, .TICK_PRESCALER_CLEAR, .SFR_RDATA, .BASE_TICK,
    .PULSE_100US, .IRQ);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Cycles until the tick or the flag is seen high, at most lim
  task automatic wait_hi(input bit t, input int lim, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while ((t ? BASE_TICK : IRQ) !== 1'b1 && n < lim);
  endtask : wait_hi
  task automatic t_reg;
    logic [7:0] d;
    u_core.rd(8'h9c, d);
    check(d, 8'h00);
    u_core.wr(8'h9c, 8'hff);
    u_core.rd(8'h9c, d);
    check(d, 8'hc7);
    check(IRQ, 1'b1);
    u_core.rd(8'h55, d);
    check(d, 8'h00);
    u_core.wr(8'h9c, 8'h40);
    u_core.rd(8'h9c, d);
    check(d, 8'h40);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_tick;
    int n;
    @(posedge CLK) SYS_DIV <= 3'h0;
    repeat (2) wait_hi(1'b1, 300, n);
    check(n, 128);
    @(posedge CLK) SYS_DIV <= 3'h3;
    repeat (2) wait_hi(1'b1, 300, n);
    check(n, 16);
    u_core.wr(8'h9c, 8'h03);
    wait_hi(1'b1, 64, n);
    check(n, 64);
    @(posedge CLK) SYS_DIV <= 3'h7;
    $display("t_tick done");
  endtask : t_tick
  task automatic t_sel;
    int n;
    int total;
    for (int s = 0; s < 8; s++) begin
      u_core.wr(8'h9c, 8'h60 | s);
      wait_hi(1'b0, (s == 0) ? exp_t[0] : 5000, n);
      total = 0;
      if (s == 0) begin
        check(n, exp_t[0]);
        check(IRQ, 1'b0);
      end else begin
        repeat (4) begin
          u_core.wr(8'h9c, 8'h40 | s);
          wait_hi(1'b0, 5000, n);
          total += n + 2;
        end
        check(total, exp_t[s]);
      end
    end
    u_core.wr(8'h9c, 8'h40);
    $display("t_sel done");
  endtask : t_sel
  task automatic t_sync;
    int n;
    @(posedge CLK) SYS_DIV <= 3'h0;
    u_core.sync(8'h41);
    wait_hi(1'b1, 300, n);
    check(n, 128);
    wait_hi(1'b0, 3000, n);
    check(IRQ, 1'b1);
    // 18 more ticks of 128 cycles, then two cycles of flag latency
    check(n, 18 * 128 + 2);
    $display("t_sync done");
  endtask : t_sync
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    t_reg();
    t_tick();
    t_sel();
    t_sync();
    final_report();
  end
endmodule : tb_top
